// ===== hw/cmpwm_top.sv
// Digital control core of a current-mode PWM controller with protection.
// Assumes comparator flags synchronous to clk_sys and a classic Wishbone master.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "cmpwm_params.svh"
module cmpwm_top #(
   parameter int PW = 16,
   parameter int OW = 12,
   parameter logic [OW-1:0] OLP_CYC = OW'(`CMPWM_OLP_CYC)
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire cmpwm_pkg::cmpwm_flags_t afe_flags,
   output logic gate_drive,
   output logic startup_high_voltage_pin
);

   localparam logic [PW-1:0] BLANK_CYC = PW'(`CMPWM_BLANK_CYC);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [31:0] ctrl_q;            // Enable and green-mode enable
   logic [PW-1:0] period_q;        // Normal period in clocks
   logic [PW-1:0] gperiod_q;       // Green-mode period in clocks
   logic ack_q;                    // Bus acknowledge
   logic [31:0] rdat_q;            // Bus read data
   logic undervoltage_lockout_ok_q;                // Supply lockout released
   logic olp_q;                    // Overload latch
   logic uvcnt_q;                  // Divide-by-two lockout fall count
   logic ovp_q;                    // Over-voltage latch
   logic green_q;                  // Green period in use this cycle
   logic gate_q;                   // Gate output flop
   logic hv_q;                     // Startup source enable flop
   cmpwm_pkg::cmpwm_phase_t ph_q;  // Pulse phase
   cmpwm_pkg::cmpwm_phase_t ph_d;  // Next pulse phase
   logic [PW-1:0] act_per;         // Period currently in force
   logic [PW-1:0] osc_lim;         // Last count of the period
   logic [PW-1:0] osc_cnt;         // Clocks since period start
   logic period_start;             // Oscillator wraps this cycle
   logic [PW+6:0] duty_wide;       // Duty limit before narrowing
   logic [PW-1:0] duty_lim;        // On-time limit in clocks
   logic [PW:0] on_next;           // On-time after this clock
   logic [OW-1:0] olp_cnt;         // Consecutive overload periods
   logic olp_at_lim;               // Overload count reached
   logic olp_trip;                 // Overload trips this cycle
   logic uv_rise;                  // Lockout release event
   logic uv_fall;                  // Lockout fall event
   logic pin_fault;                // Any pin fault
   logic inhibit;                  // Anything that blocks switching
   logic cs_trip;                  // Current limit past blanking
   logic duty_end;                 // Duty limit reached
   logic bus_req;                  // New bus request this cycle
   logic [31:0] wmask;             // Byte-lane write mask

   // ************************************************************
   // Event and condition decode
   // ************************************************************
   assign uv_rise = !undervoltage_lockout_ok_q && afe_flags.vdd_above_on;
   assign uv_fall = undervoltage_lockout_ok_q && afe_flags.vdd_below_off;
   assign pin_fault = afe_flags.freq_set_short | afe_flags.freq_set_open | afe_flags.cs_open;
   assign olp_trip = olp_at_lim && !olp_q;
   // Every blocking condition except a lockout fall (one edge later) stops switching on the very next edge
   assign inhibit = !undervoltage_lockout_ok_q | !ctrl_q[`CMPWM_CTRL_EN_BIT] | afe_flags.fb_off | olp_q | olp_trip
                    | ovp_q | afe_flags.vdd_ovp | pin_fault;

   // ************************************************************
   // Oscillator
   // ************************************************************
   // Green period takes over only at a period boundary, no runt cycles
   assign act_per = green_q ? gperiod_q : period_q;
   assign osc_lim = (act_per == '0) ? '0 : act_per - 1'b1;
   assign duty_wide = ((PW+7)'(act_per) * (PW+7)'(`CMPWM_DUTY_PCT)) / (PW+7)'(100);
   assign duty_lim = duty_wide[PW-1:0];
   assign on_next = {1'b0, osc_cnt} + 1'b1;

   cmpwm_cycle_counter #(
      .W(PW)
   ) u_osc (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(1'b0),
      .en(1'b1),
      .limit(osc_lim),
      .count(osc_cnt),
      .at_limit(period_start)
   );

   // Latch the light-load decision once per period
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         green_q <= 1'b0;
      end else if (period_start) begin
         green_q <= ctrl_q[`CMPWM_CTRL_GREEN_BIT] & afe_flags.fb_green;
      end
   end

   // ************************************************************
   // Pulse phase
   // ************************************************************
   // Current flag is only looked at once blanking has run out
   assign cs_trip = afe_flags.cs_over && (osc_cnt >= BLANK_CYC);
   assign duty_end = (on_next >= {1'b0, duty_lim});

   // Next phase of the gate pulse
   always_comb begin
      ph_d = ph_q;
      unique case (ph_q)
         cmpwm_pkg::CMPWM_PH_WAIT: begin
            // New pulse only at the start of a period
            if (period_start && !inhibit && duty_lim != '0) begin
               ph_d = cmpwm_pkg::CMPWM_PH_ON;
            end
         end
         cmpwm_pkg::CMPWM_PH_ON: begin
            // Any ending cause drops the gate at the next edge
            if (inhibit || cs_trip || duty_end) begin
               ph_d = cmpwm_pkg::CMPWM_PH_WAIT;
            end
         end
      endcase
   end

   // Phase register and gate flop; gate is driven low outside pulses
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ph_q <= cmpwm_pkg::CMPWM_PH_WAIT;
         gate_q <= 1'b0;
      end else begin
         ph_q <= ph_d;
         gate_q <= (ph_d == cmpwm_pkg::CMPWM_PH_ON);
      end
   end

   // ************************************************************
   // Supply lockout and startup source
   // ************************************************************
   // Hysteresis: on above upper threshold, off below lower
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         undervoltage_lockout_ok_q <= 1'b0;
         hv_q <= 1'b1;
      end else begin
         if (uv_rise) begin
            undervoltage_lockout_ok_q <= 1'b1;
         end else if (uv_fall) begin
            undervoltage_lockout_ok_q <= 1'b0;
         end
         // Source charges the supply only until the upper threshold
         hv_q <= !(undervoltage_lockout_ok_q ? !uv_fall : uv_rise);
      end
   end

   // ************************************************************
   // Overload protection
   // ************************************************************
   // Counting periods makes the delay follow the programmed frequency
   cmpwm_cycle_counter #(
      .W(OW)
   ) u_olp (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(olp_q | (period_start & !afe_flags.fb_overload)),
      .en(period_start & afe_flags.fb_overload),
      .limit(OLP_CYC),
      .count(olp_cnt),
      .at_limit(olp_at_lim)
   );

   // Latch off, then release on the second lockout fall
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         olp_q <= 1'b0;
         uvcnt_q <= 1'b0;
      end else if (olp_trip) begin
         olp_q <= 1'b1;
         uvcnt_q <= 1'b0;
      end else if (olp_q && uv_fall) begin
         if (uvcnt_q) begin
            olp_q <= 1'b0;
            uvcnt_q <= 1'b0;
         end else begin
            uvcnt_q <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Supply over-voltage
   // ************************************************************
   // Set wins over the release; persistence re-trips, giving hiccup
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ovp_q <= 1'b0;
      end else if (afe_flags.vdd_ovp) begin
         ovp_q <= 1'b1;
      end else if (uv_rise) begin
         ovp_q <= 1'b0;
      end
   end

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // One-cycle acknowledge, dropped after each answer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   // Writable registers; status and unmapped writes are ignored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CMPWM_CTRL_RST;
         period_q <= PW'(`CMPWM_PERIOD_RST);
         gperiod_q <= PW'(`CMPWM_GPERIOD_RST);
      end else if (bus_req && wb_we_i) begin
         if (wb_adr_i == `CMPWM_OFS_CTRL) begin
            ctrl_q <= ((ctrl_q & ~wmask) | (wb_dat_i & wmask)) & 32'h0000_0003;
         end
         if (wb_adr_i == `CMPWM_OFS_PERIOD) begin
            period_q <= PW'(({16'h0000, period_q} & ~wmask) | (wb_dat_i & wmask));
         end
         if (wb_adr_i == `CMPWM_OFS_GPERIOD) begin
            gperiod_q <= PW'(({16'h0000, gperiod_q} & ~wmask) | (wb_dat_i & wmask));
         end
      end
   end

   // Read data, unmapped offsets answer zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdat_q <= 32'h0000_0000;
      end else if (bus_req) begin
         unique case (wb_adr_i)
            `CMPWM_OFS_CTRL: rdat_q <= ctrl_q;
            `CMPWM_OFS_PERIOD: rdat_q <= 32'(period_q);
            `CMPWM_OFS_GPERIOD: rdat_q <= 32'(gperiod_q);
            `CMPWM_OFS_STATUS: begin
               rdat_q <= 32'h0000_0000;
               rdat_q[`CMPWM_ST_GATE] <= gate_q;
               rdat_q[`CMPWM_ST_UNDERVOLTAGE_LOCKOUT_OK] <= undervoltage_lockout_ok_q;
               rdat_q[`CMPWM_ST_OLP] <= olp_q;
               rdat_q[`CMPWM_ST_OVP] <= ovp_q;
               rdat_q[`CMPWM_ST_PINFAULT] <= pin_fault;
               rdat_q[`CMPWM_ST_OFFCTL] <= afe_flags.fb_off;
               rdat_q[`CMPWM_ST_GREEN] <= green_q;
               rdat_q[`CMPWM_ST_UVCNT] <= uvcnt_q;
            end
            default: rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign gate_drive = gate_q;
   assign startup_high_voltage_pin = hv_q;

   // ************************************************************
   // Checks
   // ************************************************************
   chk_peak_limit:
   assert property (@(posedge clk_sys) disable iff (rst)
      gate_q && afe_flags.cs_over && osc_cnt >= BLANK_CYC |=> !gate_q)
      else $error("peak current did not end the pulse");

   chk_blank_hold:
   assert property (@(posedge clk_sys) disable iff (rst)
      gate_q && osc_cnt < BLANK_CYC && !inhibit && !duty_end |=> gate_q)
      else $error("pulse ended inside blanking");

   chk_duty_cap:
   assert property (@(posedge clk_sys) disable iff (rst)
      gate_q |-> osc_cnt < duty_lim)
      else $error("on-time beyond duty limit");

   chk_lockout_gate:
   assert property (@(posedge clk_sys) disable iff (rst)
      $rose(gate_q) |-> $past(undervoltage_lockout_ok_q) && $past(period_start))
      else $error("pulse started in lockout or mid-period");

   chk_off_ctl:
   assert property (@(posedge clk_sys) disable iff (rst)
      afe_flags.fb_off |=> !gate_q)
      else $error("gate on while feedback pulled low");

   chk_olp_trip:
   assert property (@(posedge clk_sys) disable iff (rst)
      olp_at_lim && !olp_q |=> olp_q && !gate_q)
      else $error("overload count did not trip");

   chk_olp_release:
   assert property (@(posedge clk_sys) disable iff (rst)
      olp_q && uv_fall && !uvcnt_q |=> olp_q)
      else $error("overload released on first lockout fall");

   chk_olp_free:
   assert property (@(posedge clk_sys) disable iff (rst)
      olp_q && uv_fall && uvcnt_q |=> !olp_q)
      else $error("overload not released on second lockout fall");

   chk_ovp_stop:
   assert property (@(posedge clk_sys) disable iff (rst)
      afe_flags.vdd_ovp |=> ovp_q && !gate_q)
      else $error("over-voltage did not stop the gate");

   chk_pin_fault:
   assert property (@(posedge clk_sys) disable iff (rst)
      pin_fault |=> !gate_q)
      else $error("gate on during pin fault");

   chk_hv_off:
   assert property (@(posedge clk_sys) disable iff (rst)
      $rose(undervoltage_lockout_ok_q) |-> !hv_q ##1 (!hv_q || !undervoltage_lockout_ok_q))
      else $error("startup source on after lockout release");

endmodule // cmpwm_top
`default_nettype wire

// ===== hw/cmpwm_params.svh
// Constants of the current-mode PWM control core: offsets, fields, resets, timing.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef CMPWM_PARAMS_SVH
`define CMPWM_PARAMS_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define CMPWM_CLK_HZ 10000000
`define CMPWM_CLK_MHZ 10
`define CMPWM_NORM_HZ 65000
`define CMPWM_GREEN_HZ 20000
`define CMPWM_BLANK_NS 350
`define CMPWM_BLANK_CYC ((`CMPWM_BLANK_NS * `CMPWM_CLK_MHZ + 999) / 1000)
`define CMPWM_DUTY_PCT 75
`define CMPWM_OLP_MS 30
`define CMPWM_OLP_CYC ((`CMPWM_OLP_MS * `CMPWM_NORM_HZ) / 1000)
`define CMPWM_PERIOD_RST (`CMPWM_CLK_HZ / `CMPWM_NORM_HZ)
`define CMPWM_GPERIOD_RST (`CMPWM_CLK_HZ / `CMPWM_GREEN_HZ)

// ************************************************************
// Register map (byte addresses)
// ************************************************************
`define CMPWM_OFS_CTRL 8'h00
`define CMPWM_OFS_PERIOD 8'h04
`define CMPWM_OFS_GPERIOD 8'h08
`define CMPWM_OFS_STATUS 8'h0C
`define CMPWM_CTRL_RST 32'h0000_0003
`define CMPWM_CTRL_EN_BIT 0
`define CMPWM_CTRL_GREEN_BIT 1

// Status fields
`define CMPWM_ST_GATE 0
`define CMPWM_ST_UNDERVOLTAGE_LOCKOUT_OK 1
`define CMPWM_ST_OLP 2
`define CMPWM_ST_OVP 3
`define CMPWM_ST_PINFAULT 4
`define CMPWM_ST_OFFCTL 5
`define CMPWM_ST_GREEN 6
`define CMPWM_ST_UVCNT 7

`endif

// ===== hw/cmpwm_pkg.sv
// Types of the current-mode PWM control core.
// Assumes the constants header is included by each design file.
package cmpwm_pkg;

   // Comparator flags from the analog front end, all active high
   typedef struct packed {
      logic cs_over;         // Sensed current at peak limit
      logic fb_off;          // Feedback pulled below off threshold
      logic fb_green;        // Feedback below green-mode threshold
      logic fb_overload;     // Feedback above overload threshold
      logic vdd_above_on;    // Supply above upper lockout threshold
      logic vdd_below_off;   // Supply below lower lockout threshold
      logic vdd_ovp;         // Supply above over-voltage level
      logic freq_set_short;  // Frequency-set pin shorted to ground
      logic freq_set_open;   // Frequency-set pin floating
      logic cs_open;         // Current-sense pin floating
   } cmpwm_flags_t;

   // Phase of the gate pulse within one period
   typedef enum logic {
      CMPWM_PH_WAIT,
      CMPWM_PH_ON
   } cmpwm_phase_t;

endpackage

// ===== hw/cmpwm_cycle_counter.sv
// Wrapping up-counter with synchronous clear and a terminal flag.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module cmpwm_cycle_counter #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clr,
   input wire logic en,
   input wire logic [W-1:0] limit,
   output logic [W-1:0] count,
   output logic at_limit
);

   logic [W-1:0] count_q; // Current count

   // ************************************************************
   // Counter
   // ************************************************************
   // Clear wins over counting; wraps once the limit is reached or passed,
   // so a limit lowered below the count cannot stall a full roll-over
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (clr) begin
         count_q <= '0;
      end else if (en) begin
         count_q <= (count_q >= limit) ? '0 : count_q + 1'b1;
      end
   end

   assign count = count_q;
   assign at_limit = (count_q >= limit);

endmodule // cmpwm_cycle_counter
`default_nettype wire

// ===== verif/cmpwm_afe_model.sv
// Behavioural analog front end and switch current seen by the PWM core.
// Assumes the bench sets static conditions by non-blocking assignment at clk_sys edges.
`timescale 1ns/10ps
`default_nettype none
module cmpwm_afe_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic gate_drive,
   input wire cmpwm_pkg::cmpwm_flags_t env,
   input wire logic [7:0] ramp,
   input wire logic spike,
   output var cmpwm_pkg::cmpwm_flags_t afe_flags
);
   // ************************************************************
   // Switch current ramp
   // ************************************************************
   logic [7:0] on_q; // Cycles the switch has been conducting

   // Current builds only while the gate is high and collapses when it opens
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         on_q <= 8'h00;
      end else if (gate_drive) begin
         on_q <= on_q + 8'h01;
      end else begin
         on_q <= 8'h00;
      end
   end

   // ************************************************************
   // Comparator outputs
   // ************************************************************
   // Spike exists only just after turn-on, so a correct core never sees it end a pulse
   always_comb begin
      afe_flags = env; // Supply, feedback pull-low and pin conditions from the bench
      afe_flags.cs_over = gate_drive && ((ramp != 8'h00 && on_q >= ramp) || (spike && on_q < 8'h03));
   end
endmodule // cmpwm_afe_model
`default_nettype wire

// ===== verif/cmpwm_top_tb.sv
// Self-checking bench for the PWM control core: bus, pulse timing and protections.
// Assumes the front-end model file is compiled before it.
`timescale 1ns/10ps
`default_nettype none
module cmpwm_top_tb;
   // ************************************************************
   // Signals
   // ************************************************************
   logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, gate_drive, startup_high_voltage_pin, spike, q;
   logic [7:0] wb_adr_i, ramp;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   cmpwm_pkg::cmpwm_flags_t env, afe_flags;
   int err_count = 0;
   int num_checks = 0;
   int cyc_cnt = 0;
   int on_c, per_c;
   localparam int OLP_N = 4; // Short overload count keeps the run brief

   cmpwm_top #(.OLP_CYC(12'(OLP_N))) i_cmpwm_top (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .afe_flags(afe_flags), .gate_drive(gate_drive),
      .startup_high_voltage_pin(startup_high_voltage_pin));
   cmpwm_afe_model i_cmpwm_afe_model (.clk_sys(clk_sys), .rst(rst), .gate_drive(gate_drive), .env(env),
      .ramp(ramp), .spike(spike), .afe_flags(afe_flags));

   // 10 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic single cycle; waits for ack with no assumed latency
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   // Skips one pulse so a setting change has settled, then times the next
   task automatic measure();
      repeat (2) begin
         while (gate_drive === 1'b1) @(posedge clk_sys);
         while (gate_drive !== 1'b1) @(posedge clk_sys);
      end
      on_c = 0;
      while (gate_drive === 1'b1) begin
         @(posedge clk_sys);
         on_c++;
      end
      per_c = on_c;
      while (gate_drive !== 1'b1) begin
         @(posedge clk_sys);
         per_c++;
      end
   endtask

   task automatic quiet(input int n, output logic hi);
      hi = 1'b0;
      repeat (n) begin
         @(posedge clk_sys);
         if (gate_drive !== 1'b0) hi = 1'b1;
      end
   endtask

   // Supply dips into lockout and comes back above the upper threshold
   task automatic uv_cycle();
      @(posedge clk_sys);
      env.vdd_above_on <= 1'b0;
      env.vdd_below_off <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(startup_high_voltage_pin, 1);
      env.vdd_below_off <= 1'b0;
      env.vdd_above_on <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask

   // Raises one flag mid-pulse; the gate must be low by the second edge after it and stay low
   task automatic hit(input int b);
      logic h;
      @(posedge clk_sys);
      while (gate_drive !== 1'b1) @(posedge clk_sys);
      env[b] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(gate_drive, 0);
      quiet(100, h);
      chk(h, 0);
      env[b] <= 1'b0;
   endtask

   // Hang guard, generous against some 5000 expected cycles
   always @(posedge clk_sys) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000) begin
         err_count++;
         final_report();
      end
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      env = '0;
      ramp = 8'h00;
      spike = 1'b0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      chk(gate_drive, 0);
      chk(startup_high_voltage_pin, 1);
      wb(0, 8'h00, 0);
      chk(rd, 32'h0000_0003);
      wb(0, 8'h04, 0);
      chk(rd, 32'h0000_0099);
      wb(0, 8'h08, 0);
      chk(rd, 32'h0000_01F4);
      wb(0, 8'h10, 0);
      chk(rd, 32'h0000_0000);
      quiet(300, q);
      chk(q, 0);
      $display("test reset done");
      env.vdd_above_on <= 1'b1;
      measure();
      chk(startup_high_voltage_pin, 0);
      chk(on_c, 114);
      chk(per_c, 153);
      wb(1, 8'h04, 32'h0000_0028);
      measure();
      chk(on_c, 30);
      chk(per_c, 40);
      $display("test startup and duty done");
      ramp <= 8'h0A;
      measure();
      chk(on_c, 11);
      ramp <= 8'h00;
      spike <= 1'b1;
      measure();
      chk(on_c, 30);
      spike <= 1'b0;
      $display("test current sense done");
      hit(8);
      measure();
      chk(per_c, 40);
      wb(1, 8'h08, 32'h0000_0064);
      env.fb_green <= 1'b1;
      measure();
      chk(per_c, 100);
      // Green enable cleared: light load must fall back to the normal period
      wb(1, 8'h00, 32'h0000_0001);
      measure();
      chk(per_c, 40);
      // Enable cleared: no pulse may start at all
      wb(1, 8'h00, 32'h0000_0000);
      quiet(300, q);
      chk(q, 0);
      wb(1, 8'h00, 32'h0000_0003);
      env.fb_green <= 1'b0;
      measure();
      chk(per_c, 40);
      $display("test off control and green done");
      env.fb_overload <= 1'b1;
      repeat (100) @(posedge clk_sys);
      env.fb_overload <= 1'b0;
      repeat (60) @(posedge clk_sys);
      env.fb_overload <= 1'b1;
      repeat (100) @(posedge clk_sys);
      env.fb_overload <= 1'b0;
      measure();
      chk(on_c, 30);
      env.fb_overload <= 1'b1;
      repeat (300) @(posedge clk_sys);
      quiet(100, q);
      chk(q, 0);
      wb(0, 8'h0C, 0);
      chk(rd[2], 1);
      env.fb_overload <= 1'b0;
      uv_cycle();
      wb(0, 8'h0C, 0);
      chk(rd[7], 1);
      quiet(100, q);
      chk(q, 0);
      uv_cycle();
      measure();
      chk(on_c, 30);
      $display("test overload done");
      hit(3);
      quiet(100, q);
      chk(q, 0);
      env.vdd_ovp <= 1'b1;
      uv_cycle();
      quiet(100, q);
      chk(q, 0);
      env.vdd_ovp <= 1'b0;
      uv_cycle();
      measure();
      chk(on_c, 30);
      $display("test over-voltage done");
      for (int b = 0; b < 3; b++) begin
         hit(b);
         uv_cycle();
      end
      $display("test pin faults done");
      // Reset in mid-run: outputs and the period register return to their reset values
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      chk(gate_drive, 0);
      chk(startup_high_voltage_pin, 1);
      wb(0, 8'h04, 0);
      chk(rd, 32'h0000_0099);
      measure();
      chk(per_c, 153);
      $display("test second reset done");
      final_report();
   end
endmodule // cmpwm_top_tb
`default_nettype wire
